//--- inc/gvpi_pkg.sv
// Shared constants, types and helpers of the gas valve process image.
// Assumes one 125 MHz clock shared by the device end and the master end.
package gvpi_pkg;
   typedef logic [15:0] gvpi_word_t;

   // Timing
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned LOCK_MS = 150;
   localparam int unsigned LOCK_CYC = LOCK_MS * (CLK_HZ / 1000);
   localparam int unsigned CAL_S = 15;
   localparam int unsigned CAL_CYC = CAL_S * CLK_HZ;
   localparam int unsigned XCHG_US = 1000;
   localparam int unsigned XCHG_CYC = XCHG_US * (CLK_HZ / 1_000_000);

   // Gas-selection control word bits
   localparam int GS_GAS2 = 0;
   localparam int GS_GAS1 = 1;
   localparam int GS_GAS3 = 2;
   localparam int GS_CAL = 3;
   localparam int GS_VLV_W = 3;

   // Status word bits
   localparam int ST_REACHED = 0;
   localparam int ST_READY = 1;
   localparam int ST_WARN = 2;
   localparam int ST_ERR = 3;
   localparam int ST_CAL = 4;

   // Tolerance window layout, tenths of a percent per byte
   localparam int TOL_HI_LSB = 8;
   localparam logic [7:0] TOL_MAX = 8'haa;

   // Value ranges
   localparam gvpi_word_t SETP_MAX = 16'h7530;
   localparam gvpi_word_t OUTLET_MAX = 16'h7530;
   localparam gvpi_word_t INLET_MAX = 16'h9c40;
   localparam gvpi_word_t DRIVE_MAX = 16'h2710;
   localparam gvpi_word_t SERIAL_MIN = 16'h0001;
   localparam gvpi_word_t SERIAL_MAX = 16'h270f;
   localparam gvpi_word_t WORD_ZERO = 16'h0000;
   // Arbitrary neutral firmware revision
   localparam gvpi_word_t FW_REV_DEF = 16'h0100;

   // Ratio factors
   localparam logic [10:0] PERMIL = 11'h3e8;
   localparam logic [10:0] PCT = 11'h064;
   localparam logic [10:0] WARN_PCT = 11'h06e;
   localparam logic [10:0] ERR_PCT = 11'h069;

   // Master register map, word index of the byte address
   localparam logic [3:0] HR_SETP = 4'h0;
   localparam logic [3:0] HR_GSEL = 4'h1;
   localparam logic [3:0] HR_TOL = 4'h2;
   localparam logic [3:0] HR_CTRL = 4'h3;
   localparam logic [3:0] HR_RB0 = 4'h4;
   localparam logic [3:0] HR_IRQ_STA = 4'he;
   localparam logic [3:0] HR_IRQ_MSK = 4'hf;
   localparam int RB_N = 10;
   localparam int RB_STATUS = 9;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_ONCE = 1;

   // Interrupt bits
   localparam int IRQ_W = 4;
   localparam int EV_XCHG = 0;
   localparam int EV_WARN = 1;
   localparam int EV_ERR = 2;
   localparam int EV_READY = 3;

   function automatic logic [26:0] gvpi_scale(input gvpi_word_t v, input logic [10:0] f);
      gvpi_scale = {11'h000, v} * {16'h0000, f};
   endfunction

   function automatic gvpi_word_t gvpi_clamp(input gvpi_word_t v, input gvpi_word_t lo,
                                              input gvpi_word_t hi);
      gvpi_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
endpackage

//--- inc/gvpi_if.sv
// Process image exchanged once per fieldbus cycle.
// Assumes both ends run on the same clock; stb and upd are one-cycle pulses.
`timescale 1ns/1ps
interface gvpi_if;
   logic stb;
   logic upd;
   logic [15:0] setpoint;
   logic [15:0] gas_sel;
   logic [15:0] tol_set;
   logic [15:0] outlet;
   logic [15:0] inlet;
   logic [15:0] drive;
   logic [15:0] serial;
   logic [15:0] fw_rev;
   logic [15:0] spare1;
   logic [15:0] spare2;
   logic [15:0] spare3;
   logic [15:0] tol_rb;
   logic [15:0] status;

   modport dev (
      input stb, setpoint, gas_sel, tol_set,
      output upd, outlet, inlet, drive, serial, fw_rev, spare1, spare2, spare3, tol_rb, status
   );
   modport host (
      output stb, setpoint, gas_sel, tol_set,
      input upd, outlet, inlet, drive, serial, fw_rev, spare1, spare2, spare3, tol_rb, status
   );
endinterface

//--- verilog/gvpi_dev.sv
// Device end of the gas valve process image: valves, status and calibration.
// Assumes sensor words come from logic on mclk and the master pulses stb.
//
// Notes on behaviour
// - serial number reported, range 1 to 9999
// - applied tolerance window read back
// - control bit 0 switches gas 2 valve
// - control bit 1 switches gas 1 valve
// - control bit 2 switches gas 3 valve
// - control bit 3 requests offset self-calibration
// - status bit 0: outlet inside window
// - status bit 1: controller ready
// - status bit 2: inlet below 110 percent
// - status bit 3: inlet below 105 percent
// - status bit 4 high during calibration
// - window: upper high byte, lower low byte, max 170
// - setpoint 0 to 30000 mbar, linear
// - selection ignored 150 ms after gas off
// - at most one gas valve open
// - calibration lasts 15 s, then ready
`timescale 1ns/1ps
module gvpi_dev #(
   parameter int unsigned LOCK_CYCLES = gvpi_pkg::LOCK_CYC,
   parameter int unsigned CAL_CYCLES = gvpi_pkg::CAL_CYC,
   parameter gvpi_pkg::gvpi_word_t FW_REV = gvpi_pkg::FW_REV_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   gvpi_if.dev pi,
   input wire gvpi_pkg::gvpi_word_t outlet_meas,
   input wire gvpi_pkg::gvpi_word_t inlet_meas,
   input wire gvpi_pkg::gvpi_word_t drive_meas,
   input wire gvpi_pkg::gvpi_word_t serial_meas,
   output logic [gvpi_pkg::GS_VLV_W-1:0] valve_on,
   output logic calibrating
);
   import gvpi_pkg::*;

   typedef enum logic [1:0] {GVPI_INIT, GVPI_RUN, GVPI_CAL} gvpi_mode_t;

   ////////////////////////////////////////////////////////////////////////////
   // Words taken from the master

   gvpi_word_t setp_ff;
   gvpi_word_t nxt_setp;
   gvpi_word_t sel_ff;
   gvpi_word_t nxt_sel;
   logic [7:0] tol_hi_ff;
   logic [7:0] nxt_tol_hi;
   logic [7:0] tol_lo_ff;
   logic [7:0] nxt_tol_lo;
   logic upd_ff;
   logic nxt_upd;

   always_comb begin
      nxt_setp = setp_ff;
      nxt_sel = sel_ff;
      nxt_tol_hi = tol_hi_ff;
      nxt_tol_lo = tol_lo_ff;
      nxt_upd = pi.stb;
      if (pi.stb) begin
         nxt_setp = gvpi_clamp(pi.setpoint, WORD_ZERO, SETP_MAX);
         nxt_sel = pi.gas_sel;
         // Out-of-range bytes saturate rather than wrap
         nxt_tol_hi = (pi.tol_set[15:TOL_HI_LSB] > TOL_MAX) ?
                      TOL_MAX : pi.tol_set[15:TOL_HI_LSB];
         nxt_tol_lo = (pi.tol_set[TOL_HI_LSB-1:0] > TOL_MAX) ?
                      TOL_MAX : pi.tol_set[TOL_HI_LSB-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         setp_ff <= WORD_ZERO;
         sel_ff <= WORD_ZERO;
         tol_hi_ff <= 8'h00;
         tol_lo_ff <= 8'h00;
         upd_ff <= 1'b0;
      end else begin
         setp_ff <= nxt_setp;
         sel_ff <= nxt_sel;
         tol_hi_ff <= nxt_tol_hi;
         tol_lo_ff <= nxt_tol_lo;
         upd_ff <= nxt_upd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode: power-on initialisation, operation, self-calibration

   gvpi_mode_t mode_ff;
   gvpi_mode_t nxt_mode;
   logic [31:0] tmr_ff;
   logic [31:0] nxt_tmr;
   logic armed_ff;
   logic nxt_armed;

   always_comb begin
      nxt_mode = mode_ff;
      nxt_tmr = tmr_ff;
      // A held request starts one calibration only; bit must drop first
      nxt_armed = armed_ff & sel_ff[GS_CAL];
      case (mode_ff)
         GVPI_INIT, GVPI_CAL: begin
            if (tmr_ff >= CAL_CYCLES - 1) begin
               nxt_mode = GVPI_RUN;
               nxt_tmr = 32'h0000_0000;
            end else begin
               nxt_tmr = tmr_ff + 32'h0000_0001;
            end
         end
         GVPI_RUN: begin
            if (sel_ff[GS_CAL] && !armed_ff) begin
               nxt_mode = GVPI_CAL;
               nxt_armed = 1'b1;
               nxt_tmr = 32'h0000_0000;
            end
         end
         default: begin
            nxt_mode = GVPI_INIT;
            nxt_tmr = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= GVPI_INIT;
         tmr_ff <= 32'h0000_0000;
         armed_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         tmr_ff <= nxt_tmr;
         armed_ff <= nxt_armed;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Upstream valves with interlock and switch-off lock

   logic [GS_VLV_W-1:0] vlv_ff;
   logic [GS_VLV_W-1:0] nxt_vlv;
   logic [31:0] lock_ff;
   logic [31:0] nxt_lock;
   logic [GS_VLV_W-1:0] req;
   logic req_one;

   always_comb begin
      // Bit i of the valve vector follows bit i of the control word
      req = sel_ff[GS_VLV_W-1:0];
      req_one = (req != '0) && ((req & (req - 3'b001)) == '0);
      nxt_vlv = vlv_ff;
      nxt_lock = (lock_ff != 32'h0000_0000) ? lock_ff - 32'h0000_0001 : lock_ff;
      if (lock_ff == 32'h0000_0000) begin
         if (vlv_ff != '0) begin
            // Gas off on cleared bit or when leaving operation
            if (((vlv_ff & req) == '0) || (mode_ff != GVPI_RUN)) begin
               nxt_vlv = '0;
               nxt_lock = LOCK_CYCLES;
            end
         end else if ((mode_ff == GVPI_RUN) && req_one) begin
            // Several bits at once open nothing, a safe reading of the interlock
            nxt_vlv = req;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vlv_ff <= '0;
         lock_ff <= 32'h0000_0000;
      end else begin
         vlv_ff <= nxt_vlv;
         lock_ff <= nxt_lock;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Image words returned to the master

   gvpi_word_t out_ff;
   gvpi_word_t nxt_out;
   gvpi_word_t in_ff;
   gvpi_word_t nxt_in;
   gvpi_word_t drv_ff;
   gvpi_word_t nxt_drv;
   gvpi_word_t ser_ff;
   gvpi_word_t nxt_ser;
   gvpi_word_t sta_ff;
   gvpi_word_t nxt_sta;
   logic cal_ff;
   logic nxt_cal;
   logic [26:0] out_k;
   logic [26:0] in_k;

   always_comb begin
      nxt_out = gvpi_clamp(outlet_meas, WORD_ZERO, OUTLET_MAX);
      nxt_in = gvpi_clamp(inlet_meas, WORD_ZERO, INLET_MAX);
      nxt_drv = gvpi_clamp(drive_meas, WORD_ZERO, DRIVE_MAX);
      nxt_ser = gvpi_clamp(serial_meas, SERIAL_MIN, SERIAL_MAX);
      nxt_cal = (mode_ff == GVPI_CAL);
      out_k = gvpi_scale(out_ff, PERMIL);
      in_k = gvpi_scale(in_ff, PCT);
      // Compare by cross-multiplying, avoiding a divider
      nxt_sta = WORD_ZERO;
      nxt_sta[ST_REACHED] = (out_k <= gvpi_scale(setp_ff, PERMIL + {3'b000, tol_hi_ff})) &&
                            (out_k >= gvpi_scale(setp_ff, PERMIL - {3'b000, tol_lo_ff}));
      nxt_sta[ST_READY] = (mode_ff == GVPI_RUN);
      nxt_sta[ST_WARN] = in_k < gvpi_scale(setp_ff, WARN_PCT);
      nxt_sta[ST_ERR] = in_k < gvpi_scale(setp_ff, ERR_PCT);
      nxt_sta[ST_CAL] = nxt_cal;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= WORD_ZERO;
         in_ff <= WORD_ZERO;
         drv_ff <= WORD_ZERO;
         ser_ff <= SERIAL_MIN;
         sta_ff <= WORD_ZERO;
         cal_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
         in_ff <= nxt_in;
         drv_ff <= nxt_drv;
         ser_ff <= nxt_ser;
         sta_ff <= nxt_sta;
         cal_ff <= nxt_cal;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign pi.upd = upd_ff;
   assign pi.outlet = out_ff;
   assign pi.inlet = in_ff;
   assign pi.drive = drv_ff;
   assign pi.serial = ser_ff;
   assign pi.fw_rev = FW_REV;
   // Spare words carry nothing
   assign pi.spare1 = WORD_ZERO;
   assign pi.spare2 = WORD_ZERO;
   assign pi.spare3 = WORD_ZERO;
   assign pi.tol_rb = {tol_hi_ff, tol_lo_ff};
   assign pi.status = sta_ff;
   assign valve_on = vlv_ff;
   assign calibrating = cal_ff;
endmodule // gvpi_dev

//--- verilog/gvpi_host.sv
// Master end of the process image: Avalon-MM registers, cyclic exchange, interrupt.
// Assumes an Avalon-MM master on mclk and the device end on the same interface.
`timescale 1ns/1ps
module gvpi_host #(
   parameter int unsigned XCHG_CYCLES = gvpi_pkg::XCHG_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   gvpi_if.host pi,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq
);
   import gvpi_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait state, answer on the edge waitrequest is low

   logic wait_ff;
   logic nxt_wait;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic acc;
   logic [3:0] idx;

   gvpi_word_t setp_ff, nxt_setp, sel_ff, nxt_sel, tol_ff, nxt_tol;
   logic [1:0] ctrl_ff, nxt_ctrl;
   gvpi_word_t rb_ff [RB_N];
   logic [IRQ_W-1:0] ista_ff, nxt_ista, imsk_ff, nxt_imsk, ev;
   logic irq_ff, nxt_irq, stb_ff, nxt_stb;
   logic [31:0] per_ff, nxt_per;

   assign idx = address[5:2];
   assign acc = (read | write) & ~wait_ff;

   always_comb begin
      nxt_wait = ~((read | write) & wait_ff);
      nxt_rdata = rdata_ff;
      if (read && wait_ff) begin
         case (idx)
            HR_SETP: nxt_rdata = {16'h0000, setp_ff};
            HR_GSEL: nxt_rdata = {16'h0000, sel_ff};
            HR_TOL: nxt_rdata = {16'h0000, tol_ff};
            HR_CTRL: nxt_rdata = {30'h0000_0000, ctrl_ff};
            HR_IRQ_STA: nxt_rdata = {28'h000_0000, ista_ff};
            HR_IRQ_MSK: nxt_rdata = {28'h000_0000, imsk_ff};
            default: nxt_rdata = {16'h0000, rb_ff[4'(idx - HR_RB0)]};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers and exchange timer

   always_comb begin
      nxt_setp = setp_ff;
      nxt_sel = sel_ff;
      nxt_tol = tol_ff;
      nxt_imsk = imsk_ff;
      nxt_ctrl = ctrl_ff;
      nxt_ctrl[CTRL_ONCE] = 1'b0;
      if (acc && write) begin
         case (idx)
            HR_SETP: nxt_setp = gvpi_clamp(writedata[15:0], WORD_ZERO, SETP_MAX);
            HR_GSEL: nxt_sel = writedata[15:0];
            HR_TOL: nxt_tol = writedata[15:0];
            HR_CTRL: nxt_ctrl = writedata[1:0];
            HR_IRQ_MSK: nxt_imsk = writedata[IRQ_W-1:0];
            default: nxt_ctrl[CTRL_ONCE] = 1'b0;
         endcase
      end
      nxt_stb = 1'b0;
      nxt_per = per_ff;
      if (ctrl_ff[CTRL_RUN]) begin
         if (per_ff >= XCHG_CYCLES - 1) begin
            nxt_per = 32'h0000_0000;
            nxt_stb = 1'b1;
         end else begin
            nxt_per = per_ff + 32'h0000_0001;
         end
      end else begin
         nxt_per = 32'h0000_0000;
         nxt_stb = ctrl_ff[CTRL_ONCE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events from the returned image; set beats clear

   always_comb begin
      ev = '0;
      if (pi.upd) begin
         ev[EV_XCHG] = 1'b1;
         ev[EV_WARN] = pi.status[ST_WARN] & ~rb_ff[RB_STATUS][ST_WARN];
         ev[EV_ERR] = pi.status[ST_ERR] & ~rb_ff[RB_STATUS][ST_ERR];
         ev[EV_READY] = pi.status[ST_READY] & ~rb_ff[RB_STATUS][ST_READY];
      end
      nxt_ista = ista_ff;
      if (acc && write && (idx == HR_IRQ_STA)) begin
         nxt_ista = ista_ff & ~writedata[IRQ_W-1:0];
      end
      nxt_ista = nxt_ista | ev;
      nxt_irq = |(ista_ff & imsk_ff);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
         setp_ff <= WORD_ZERO;
         sel_ff <= WORD_ZERO;
         tol_ff <= WORD_ZERO;
         ctrl_ff <= 2'b00;
         imsk_ff <= '0;
         ista_ff <= '0;
         irq_ff <= 1'b0;
         stb_ff <= 1'b0;
         per_ff <= 32'h0000_0000;
         for (int i = 0; i < RB_N; i++) begin
            rb_ff[i] <= WORD_ZERO;
         end
      end else begin
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
         setp_ff <= nxt_setp;
         sel_ff <= nxt_sel;
         tol_ff <= nxt_tol;
         ctrl_ff <= nxt_ctrl;
         imsk_ff <= nxt_imsk;
         ista_ff <= nxt_ista;
         irq_ff <= nxt_irq;
         stb_ff <= nxt_stb;
         per_ff <= nxt_per;
         if (pi.upd) begin
            // Spare words are captured but carry nothing
            rb_ff[0] <= pi.outlet;
            rb_ff[1] <= pi.inlet;
            rb_ff[2] <= pi.drive;
            rb_ff[3] <= pi.serial;
            rb_ff[4] <= pi.fw_rev;
            rb_ff[5] <= pi.spare1;
            rb_ff[6] <= pi.spare2;
            rb_ff[7] <= pi.spare3;
            rb_ff[8] <= pi.tol_rb;
            rb_ff[RB_STATUS] <= pi.status;
         end
      end
   end

   assign readdata = rdata_ff;
   assign waitrequest = wait_ff;
   assign irq = irq_ff;
   assign pi.stb = stb_ff;
   assign pi.setpoint = setp_ff;
   assign pi.gas_sel = sel_ff;
   assign pi.tol_set = tol_ff;
endmodule // gvpi_host

//--- test/gvpi_chk.sv
// Assertions on the process image link between device and master end.
// Assumes one clock; the link signals arrive as plain inputs.
`timescale 1ns/1ps
module gvpi_chk #(
   parameter int CAL_CYCLES = 50
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic stb,
   input wire logic upd,
   input wire logic [15:0] outlet,
   input wire logic [15:0] inlet,
   input wire logic [15:0] drive,
   input wire logic [15:0] serial,
   input wire logic [15:0] spare1,
   input wire logic [15:0] spare2,
   input wire logic [15:0] spare3,
   input wire logic [15:0] tol_rb,
   input wire logic [15:0] status
);
   int cal_cnt_ff;
   int nxt_cal_cnt;
   ////////////////////////////////
   always_comb begin
      nxt_cal_cnt = status[4] ? cal_cnt_ff + 1 : 0;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cal_cnt_ff <= 0;
      end else begin
         cal_cnt_ff <= nxt_cal_cnt;
      end
   end
   ////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_upd_follows: assert property (stb |=> upd)
      else $error("update pulse missing after strobe");
   chk_upd_cause: assert property (upd |-> $past(stb))
      else $error("update pulse without strobe");
   chk_drive_range: assert property (drive <= 16'h2710)
      else $error("drive word above limit");
   chk_serial_range: assert property (serial >= 16'h0001 && serial <= 16'h270f)
      else $error("serial word out of range");
   chk_press_range: assert property (outlet <= 16'h7530 && inlet <= 16'h9c40)
      else $error("pressure word out of range");
   chk_spare_zero: assert property ((spare1 | spare2 | spare3) == 16'h0000)
      else $error("spare word not zero");
   chk_tol_bytes: assert property (tol_rb[15:8] <= 8'haa && tol_rb[7:0] <= 8'haa)
      else $error("window byte above limit");
   chk_err_warn: assert property (status[3] |-> status[2])
      else $error("error flag without warning flag");
   chk_cal_busy: assert property (status[4] |-> !status[1])
      else $error("ready during calibration");
   chk_cal_length: assert property ($fell(status[4]) |->
      cal_cnt_ff >= CAL_CYCLES - 1 && cal_cnt_ff <= CAL_CYCLES + 1)
      else $error("calibration length wrong");
   chk_ready_back: assert property ($fell(status[4]) |-> status[1])
      else $error("ready not back after calibration");
   cover property (upd);
   cover property ($rose(status[4]));
   cover property (status[0] && status[1]);
   cover property (status[3]);
endmodule // gvpi_chk

//--- test/gvpi_tb.sv
// Bench joining device end and master end; software side over Avalon-MM.
// Assumes shortened lock, calibration and exchange counts.
`timescale 1ns/1ps
module gvpi_tb;
   localparam logic [15:0] FW = 16'h0203; // Arbitrary revision value
   logic mclk, rst_n, read, write, waitrequest, irq, calibrating;
   logic [5:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [15:0] outlet_meas, inlet_meas, drive_meas, serial_meas;
   logic [2:0] valve_on;
   int num_errors, samples_checked;
   gvpi_if pi();
   gvpi_dev #(.LOCK_CYCLES(20), .CAL_CYCLES(50), .FW_REV(FW)) gvpi_dev_inst (.mclk(mclk),
      .rst_n(rst_n), .pi(pi), .outlet_meas(outlet_meas), .inlet_meas(inlet_meas),
      .drive_meas(drive_meas), .serial_meas(serial_meas), .valve_on(valve_on),
      .calibrating(calibrating));
   gvpi_host #(.XCHG_CYCLES(8)) gvpi_host_inst (.mclk(mclk), .rst_n(rst_n), .pi(pi),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
   gvpi_chk #(.CAL_CYCLES(50)) gvpi_chk_inst (.mclk(mclk), .rst_n(rst_n), .stb(pi.stb),
      .upd(pi.upd), .outlet(pi.outlet), .inlet(pi.inlet), .drive(pi.drive),
      .serial(pi.serial), .spare1(pi.spare1), .spare2(pi.spare2), .spare3(pi.spare3),
      .tol_rb(pi.tol_rb), .status(pi.status));
   ////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until waitrequest is seen low, then idles one edge
   task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
      int n;
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) num_errors++;
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk_rd(input logic [5:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   ////////////////////////////////
   task automatic s_interrupt;
      chk({31'h0, irq}, 32'h0000_0000);
      bus(6'h3c, 1'b1, 32'h0000_0008);
      wt(4);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(6'h38, 1'b1, 32'h0000_0008);
      wt(4);
      chk({31'h0, irq}, 32'h0000_0000);
      chk_rd(6'h34, 32'h0000_0003);
      // Exchange bit stays sticky, ready bit was cleared above
      chk_rd(6'h38, 32'h0000_0001);
      chk_rd(6'h3c, 32'h0000_0008);
      chk_rd(6'h0c, 32'h0000_0001);
   endtask
   task automatic meas(input logic [15:0] o, i, d, s, eo, ei, ed, es);
      outlet_meas <= o;
      inlet_meas <= i;
      drive_meas <= d;
      serial_meas <= s;
      wt(24);
      chk_rd(6'h10, {16'h0000, eo});
      chk_rd(6'h14, {16'h0000, ei});
      chk_rd(6'h18, {16'h0000, ed});
      chk_rd(6'h1c, {16'h0000, es});
   endtask
   task automatic s_image;
      meas(16'h9c40, 16'hc350, 16'h4e20, 16'h0000, 16'h7530, 16'h9c40, 16'h2710, 16'h0001);
      // Readback words must ignore writes
      bus(6'h10, 1'b1, 32'h0000_1234);
      meas(16'h007b, 16'h11d7, 16'h2710, 16'h3039, 16'h007b, 16'h11d7, 16'h2710, 16'h270f);
      chk_rd(6'h20, {16'h0000, FW});
      for (int a = 9; a < 12; a++) begin
         chk_rd(6'(a * 4), 32'h0000_0000);
      end
   endtask
   task automatic row(input logic [15:0] o, input logic [15:0] i, input logic [31:0] e);
      outlet_meas <= o;
      inlet_meas <= i;
      wt(24);
      chk_rd(6'h34, e);
   endtask
   task automatic s_window;
      bus(6'h00, 1'b1, 32'h0000_9c40);
      chk_rd(6'h00, 32'h0000_7530);
      bus(6'h00, 1'b1, 32'h0000_2710);
      bus(6'h08, 1'b1, 32'h0000_ffb0);
      wt(24);
      chk_rd(6'h30, 32'h0000_aaaa);
      chk_rd(6'h08, 32'h0000_ffb0);
      bus(6'h08, 1'b1, 32'h0000_0a14);
      wt(24);
      chk_rd(6'h30, 32'h0000_0a14);
      // Window 9800..10100, warning below 11000, error below 10500
      row(16'h2647, 16'h2af8, 32'h0000_0002);
      row(16'h2648, 16'h2af7, 32'h0000_0007);
      row(16'h2774, 16'h2904, 32'h0000_0007);
      row(16'h2775, 16'h2903, 32'h0000_000e);
   endtask
   task automatic s_valves;
      int n;
      for (int i = 0; i < 3; i++) begin
         bus(6'h04, 1'b1, 32'h1 << i);
         wt(40);
         chk({29'h0, valve_on}, 32'h1 << i);
         bus(6'h04, 1'b1, 32'h0000_0000);
         n = 0;
         while (valve_on !== 3'b000 && n < 40) begin
            @(posedge mclk);
            n++;
         end
         // New choice lands inside the switch-off lock
         bus(6'h04, 1'b1, 32'h1 << ((i + 1) % 3));
         wt(10);
         chk({29'h0, valve_on}, 32'h0000_0000);
         wt(40);
         chk({29'h0, valve_on}, 32'h1 << ((i + 1) % 3));
         bus(6'h04, 1'b1, 32'h0000_0000);
         wt(40);
      end
      bus(6'h04, 1'b1, 32'h0000_0003);
      wt(40);
      chk({29'h0, valve_on}, 32'h0000_0000);
      bus(6'h04, 1'b1, 32'h0000_0000);
   endtask
   task automatic s_cal;
      int n;
      bus(6'h04, 1'b1, 32'h0000_0008);
      n = 0;
      while (calibrating !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      chk({31'h0, calibrating}, 32'h0000_0001);
      chk_rd(6'h04, 32'h0000_0008);
      wt(12);
      bus(6'h34, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_0012, 32'h0000_0010);
      bus(6'h04, 1'b1, 32'h0000_0000);
      wt(70);
      bus(6'h34, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_0012, 32'h0000_0002);
   endtask
   task automatic s_once;
      bus(6'h0c, 1'b1, 32'h0000_0000);
      wt(4);
      // Cyclic exchange stopped: a new reading must not reach the image
      outlet_meas <= 16'h1234;
      wt(24);
      chk_rd(6'h10, 32'h0000_2775);
      bus(6'h0c, 1'b1, 32'h0000_0002);
      wt(8);
      chk_rd(6'h10, 32'h0000_1234);
      chk_rd(6'h0c, 32'h0000_0000);
   endtask
   ////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      writedata = 32'h0000_0000;
      outlet_meas = 16'h0000;
      inlet_meas = 16'h0000;
      drive_meas = 16'h0000;
      serial_meas = 16'h0001;
      num_errors = 0;
      samples_checked = 0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      bus(6'h0c, 1'b1, 32'h0000_0001);
      wt(80);
      s_interrupt;
      s_image;
      s_window;
      s_valves;
      s_cal;
      s_once;
      tally_and_finish;
   end
endmodule // gvpi_tb
